// ### hw/mbts_dev.sv
// documented board end of the multi-board timebase sync
// Summary of operation
// R1 - master drives its timebase to all slaves
// R2 - star route only valid for slots 3-14
// R3 - converter clocks derived from shared timebase
// R4 - cabled timebase on any line, default 8
// R5 - master sends sync on line, default 9
// R6 - sync resets converters, then aligns clock phase
// R7 - start trigger exported on lines 0 to 6
// R8 - any board exports start; all start together
// R9 - slave rate is master divided by 2^n
// R10 - lowest-rate board exports the start trigger
// R11 - alias rejection setting identical on all boards
// R12 - hold start until converters have settled
// R13 - alias rejection oversamples then decimates down
// R14 - sync after timebase; early starts ignored
// assumes: clk is the shared timebase; settings are static while go is high
`timescale 1ns/1ns
module mbts_dev import mbts_pkg::*; #(
	parameter int SETTLE_N = SETTLE_SAMPLES,
	parameter int TB_SETTLE_N = TB_SETTLE_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	mbts_if.dev link,
	input wire logic go,
	input wire logic is_master,
	input wire logic use_star,
	input wire logic [4:0] slot,
	input wire logic tb_line_sel_en,
	input wire logic [3:0] tb_line_sel,
	input wire logic sync_line_sel_en,
	input wire logic [3:0] sync_line_sel,
	input wire logic start_export,
	input wire logic [3:0] start_line,
	input wire logic start_req,
	input wire logic [3:0] rate_div_log2,
	input wire logic alias_rej,
	output logic conv_clk,
	output logic conv_rst,
	output logic acq_run,
	output logic slot_error,
	output logic [2:0] state_out
);
	mbts_state_t state;
	mbts_state_t next_state;
	logic [BTB_LINES-1:0] rx;
	logic [3:0] tb_ln;
	logic [3:0] sync_ln;
	logic [3:0] st_ln;
	logic [15:0] cnt;
	logic [15:0] div_cnt;
	logic [15:0] settle_cnt;
	logic [15:0] sync_left;
	logic [15:0] samp_mask;
	logic [3:0] eff_log2;
	logic sync_seen;
	logic sync_prev;
	logic start_prev;
	logic start_pulse;
	logic sync_rise;
	logic start_rise;
	logic slot_ok;
	logic samp_tick;

	mbts_pin_sync #(.W(BTB_LINES)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.pin(link.btb_in),
		.level(rx)
	);

	// line selection with documented defaults
	assign tb_ln = tb_line_sel_en ? tb_line_sel : TB_LINE_DEFAULT; // [R4]
	assign sync_ln = sync_line_sel_en ? sync_line_sel : SYNC_LINE_DEFAULT; // [R5]
	// out-of-range start line is clamped to the top legal line
	assign st_ln = (start_line > START_LINE_MAX) ? START_LINE_MAX : start_line; // [R7]
	assign slot_ok = !use_star || ((slot >= STAR_SLOT_MIN) && (slot <= STAR_SLOT_MAX)); // [R2]
	assign sync_rise = rx[sync_ln] && !sync_prev;
	assign start_rise = rx[st_ln] && !start_prev;
	// alias rejection runs the converter faster, so the sample tick uses fewer divide bits
	assign eff_log2 = alias_rej ? ((rate_div_log2 > ALIAS_OSR_LOG2) ?
		4'(rate_div_log2 - ALIAS_OSR_LOG2) : RATE_DIV_RESET) : rate_div_log2; // [R13]
	assign samp_mask = 16'((32'h1 << eff_log2) - 1);
	assign samp_tick = (div_cnt & samp_mask) == 16'h0000;

	// edge history of sync and start lines
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync_prev <= 1'b0;
			start_prev <= 1'b0;
		end else begin
			sync_prev <= rx[sync_ln];
			start_prev <= rx[st_ln];
		end
	end

	// sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			MBTS_IDLE: begin
				if (go && slot_ok) begin
					next_state = is_master ? MBTS_DRIVE_TB : MBTS_ARMED;
				end
			end
			MBTS_DRIVE_TB: begin
				// sync only once the timebase has been out for a while
				if (cnt >= 16'(TB_SETTLE_N - 1)) begin
					next_state = MBTS_SYNC; // [R14]
				end
			end
			MBTS_SYNC: begin
				// the master aligns on its own pulse at the same edge as every slave
				if (sync_rise) begin
					next_state = MBTS_ALIGN; // [R6]
				end else if (cnt >= 16'(SYNC_PULSE_CYC - 1)) begin
					next_state = MBTS_ARMED;
				end
			end
			MBTS_ARMED: begin
				// slaves wait here for the sync; starts now are dropped
				if (sync_rise) begin
					next_state = MBTS_ALIGN; // [R14]
				end
			end
			MBTS_ALIGN: begin
				next_state = MBTS_SETTLE; // [R6]
			end
			MBTS_SETTLE: begin
				if (start_rise && settle_cnt >= 16'(SETTLE_N)) begin
					next_state = MBTS_RUN; // [R8] [R12]
				end
			end
			MBTS_RUN: begin
				next_state = MBTS_RUN;
			end
			default: begin
				next_state = MBTS_IDLE;
			end
		endcase
		if (!go) begin
			next_state = MBTS_IDLE;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= MBTS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// per-state cycle counter
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 16'h0000;
		end else if (next_state != state) begin
			cnt <= 16'h0000;
		end else if (cnt != 16'hFFFF) begin
			cnt <= cnt + 16'h0001;
		end
	end

	// sync pulse length runs on its own count, so an early align cannot cut it short
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync_left <= 16'h0000;
		end else if (state == MBTS_IDLE) begin
			sync_left <= 16'h0000;
		end else if (state == MBTS_DRIVE_TB && next_state == MBTS_SYNC) begin
			sync_left <= 16'(SYNC_PULSE_CYC); // [R14]
		end else if (sync_left != 16'h0000) begin
			sync_left <= sync_left - 16'h0001;
		end
	end

	// converter clock divider, cleared by the sync so every board lands in phase
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt <= 16'h0000;
			conv_clk <= 1'b0;
		end else if (state == MBTS_ALIGN) begin
			div_cnt <= 16'h0000; // [R6]
			conv_clk <= 1'b0;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
			conv_clk <= div_cnt[eff_log2]; // [R3]
		end
	end

	// settle counter counts converter samples since the reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			settle_cnt <= 16'h0000;
		end else if (state != MBTS_SETTLE) begin
			settle_cnt <= 16'h0000;
		end else if (samp_tick && settle_cnt != 16'hFFFF) begin
			settle_cnt <= settle_cnt + 16'h0001; // [R12]
		end
	end

	// sync seen flag: starts before sync never count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync_seen <= 1'b0;
		end else if (state == MBTS_IDLE) begin
			sync_seen <= 1'b0;
		end else if (state == MBTS_ALIGN) begin
			sync_seen <= 1'b1; // [R14]
		end
	end

	// local start request is held until the exporter may fire it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			start_pulse <= 1'b0;
		end else begin
			start_pulse <= start_export && start_req && sync_seen &&
				state == MBTS_SETTLE && settle_cnt >= 16'(SETTLE_N); // [R8]
		end
	end

	// line drivers toward the partner boards
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			link.dev_out <= '0;
			link.dev_oe <= '0;
			link.star_tb <= 1'b0;
		end else begin
			link.dev_out <= '0;
			link.dev_oe <= '0;
			link.star_tb <= 1'b0;
			if (is_master && state != MBTS_IDLE) begin
				if (use_star) begin
					link.star_tb <= conv_clk; // [R1] [R2]
				end else begin
					link.dev_out[tb_ln] <= conv_clk; // [R1] [R4]
					link.dev_oe[tb_ln] <= 1'b1;
				end
				link.dev_out[sync_ln] <= (sync_left != 16'h0000); // [R5]
				link.dev_oe[sync_ln] <= 1'b1;
			end
			if (start_export && state != MBTS_IDLE) begin
				link.dev_out[st_ln] <= start_pulse; // [R7]
				link.dev_oe[st_ln] <= 1'b1;
			end
		end
	end

	// status outputs
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			conv_rst <= 1'b0;
			acq_run <= 1'b0;
			slot_error <= 1'b0;
			state_out <= 3'h0;
		end else begin
			// taken from the next state so the pulse lands with the slaves' reset
			conv_rst <= (next_state == MBTS_ALIGN); // [R6]
			acq_run <= (state == MBTS_RUN);
			slot_error <= go && !slot_ok; // [R2]
			state_out <= state;
		end
	end
endmodule

// ### hw/mbts_pkg.sv
// package for the multi-board timebase sync block: line numbers, states, timing
// assumes: one system clock (the shared timebase domain) at 125 MHz
package mbts_pkg;
	localparam int CLK_MHZ = 125;
	// board trigger bus has eight data lines plus timebase and sync lines: 0..9 used
	localparam int BTB_LINES = 10;
	localparam logic [3:0] TB_LINE_DEFAULT = 4'h8;
	localparam logic [3:0] SYNC_LINE_DEFAULT = 4'h9;
	localparam logic [3:0] START_LINE_MAX = 4'h6;
	// star route reaches slots 3..14
	localparam logic [4:0] STAR_SLOT_MIN = 5'h03;
	localparam logic [4:0] STAR_SLOT_MAX = 5'h0E;
	// sync pulse length in ns and in cycles (least time, rounded up)
	localparam int SYNC_PULSE_NS = 64;
	localparam int SYNC_PULSE_CYC = (SYNC_PULSE_NS * CLK_MHZ + 999) / 1000;
	// cycles the timebase must be driven before sync is issued
	localparam int TB_SETTLE_CYC = 16;
	// converter settle length in output samples after a reset
	localparam int SETTLE_SAMPLES = 64;
	// oversampling factor used when alias rejection is on (log2)
	localparam logic [3:0] ALIAS_OSR_LOG2 = 4'h2;
	localparam logic [3:0] RATE_DIV_RESET = 4'h0;

	typedef enum logic [2:0] {
		MBTS_IDLE = 3'b000,
		MBTS_DRIVE_TB = 3'b001,
		MBTS_SYNC = 3'b010,
		MBTS_ALIGN = 3'b011,
		MBTS_SETTLE = 3'b100,
		MBTS_ARMED = 3'b101,
		MBTS_RUN = 3'b110
	} mbts_state_t;
endpackage

// ### hw/mbts_if.sv
// interface carrying the shared lines between the documented board and a partner
// assumes: the bench resolves each line as wired-or of every driving end
`timescale 1ns/1ns
interface mbts_if import mbts_pkg::*; (
	input wire logic clk
);
	// board trigger bus lines, five signals per pin
	logic [BTB_LINES-1:0] btb_in;
	logic [BTB_LINES-1:0] dev_out;
	logic [BTB_LINES-1:0] dev_oe;
	logic [BTB_LINES-1:0] par_out;
	logic [BTB_LINES-1:0] par_oe;
	// backplane star route from the timebase slot
	logic star_tb;
	// resolved line level
	assign btb_in = (dev_out & dev_oe) | (par_out & par_oe);

	modport dev (input clk, input btb_in, output dev_out, output dev_oe, output star_tb);
	modport par (input clk, input btb_in, input star_tb, output par_out, output par_oe);
endinterface

// ### hw/mbts_pin_sync.sv
// three-stage synchroniser with agreement filter for one bus of pin inputs
// assumes: inputs may change at any time relative to clk
`timescale 1ns/1ns
module mbts_pin_sync #(
	parameter int W = 10
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// first stage feeds only the second; a change counts once stages 2 and 3 agree
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					s1[i] <= 1'b0;
					s2[i] <= 1'b0;
					s3[i] <= 1'b0;
					level[i] <= 1'b0;
				end else begin
					s1[i] <= pin[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (s2[i] == s3[i]) begin
						level[i] <= s3[i];
					end
				end
			end
		end
	endgenerate
endmodule

// ### hw/mbts_par.sv
// partner board end: slave sync logic on the shared lines
// assumes: the partner keeps mixed-rate and alias setting constraints by its config
`timescale 1ns/1ns
module mbts_par import mbts_pkg::*; #(
	parameter int SETTLE_N = SETTLE_SAMPLES
) (
	input wire logic clk,
	input wire logic nrst,
	mbts_if.par link,
	input wire logic go,
	input wire logic [3:0] sync_line,
	input wire logic [3:0] start_line,
	input wire logic start_export,
	input wire logic start_req,
	output logic conv_rst,
	output logic acq_run
);
	logic [BTB_LINES-1:0] rx;
	logic sync_prev;
	logic start_prev;
	logic synced;
	logic [15:0] settle_cnt;
	logic start_out;
	logic [3:0] st_ln;

	mbts_pin_sync #(.W(BTB_LINES)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.pin(link.btb_in),
		.level(rx)
	);

	assign st_ln = (start_line > START_LINE_MAX) ? START_LINE_MAX : start_line; // [R7]

	// sync and start detection; start before sync is ignored
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync_prev <= 1'b0;
			start_prev <= 1'b0;
			synced <= 1'b0;
			settle_cnt <= 16'h0000;
			conv_rst <= 1'b0;
			acq_run <= 1'b0;
			start_out <= 1'b0;
		end else begin
			sync_prev <= rx[sync_line];
			start_prev <= rx[st_ln];
			conv_rst <= 1'b0;
			start_out <= 1'b0;
			if (!go) begin
				synced <= 1'b0;
				acq_run <= 1'b0;
				settle_cnt <= 16'h0000;
			end else if (rx[sync_line] && !sync_prev) begin
				synced <= 1'b1; // [R6] [R14]
				conv_rst <= 1'b1;
				settle_cnt <= 16'h0000;
			end else if (synced && settle_cnt < 16'(SETTLE_N)) begin
				settle_cnt <= settle_cnt + 16'h0001; // [R12]
			end else if (synced) begin
				start_out <= start_export && start_req && !acq_run;
				if (rx[st_ln] && !start_prev) begin
					acq_run <= 1'b1; // [R8]
				end
			end
		end
	end

	// start trigger export from the partner side
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			link.par_out <= '0;
			link.par_oe <= '0;
		end else begin
			link.par_out <= '0;
			link.par_oe <= '0;
			if (start_export && go) begin
				link.par_out[st_ln] <= start_out; // [R7] [R10]
				link.par_oe[st_ln] <= 1'b1;
			end
		end
	end
endmodule

// ### tb/mbts_monitor.sv
// checker on the shared lines between the master end and the slave end
// assumes: sync on line 9 with timebase on line 8 or the star route; start on lines 0..6
`timescale 1ns/1ns
module mbts_monitor import mbts_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [BTB_LINES-1:0] btb_in,
	input wire logic [BTB_LINES-1:0] dev_out,
	input wire logic [BTB_LINES-1:0] dev_oe,
	input wire logic [BTB_LINES-1:0] par_out,
	input wire logic [BTB_LINES-1:0] par_oe,
	input wire logic star_tb
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// master drive of the sync line, qualified by its enable
	logic sync_drv;
	assign sync_drv = dev_out[9] & dev_oe[9];
	// the star copy has no enable, so a star line that keeps toggling counts as driven
	logic star_q;
	logic [5:0] star_idle;
	logic tb_live;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			star_q <= 1'b0;
			star_idle <= 6'h00;
		end else begin
			star_q <= star_tb;
			if (!dev_oe[9] || star_tb != star_q) begin
				star_idle <= 6'h00;
			end else if (star_idle != 6'h3F) begin
				star_idle <= star_idle + 6'h01;
			end
		end
	end
	assign tb_live = dev_oe[8] || (dev_oe[9] && star_idle < 6'h20);

	a_sync_width: assert property ($rose(sync_drv) |-> sync_drv[*8] ##1 !sync_drv)
		else $error("sync pulse length wrong");
	a_sync_after_tb: assert property ($rose(sync_drv) |-> $past(tb_live, 15))
		else $error("sync issued before timebase was driven");
	a_sync_gap: assert property ($fell(sync_drv) |=> !sync_drv[*8])
		else $error("sync pulse repeated");
	a_tb_with_sync: assert property (dev_oe[9] |-> tb_live)
		else $error("sync line driven without timebase");
	a_start_range: assert property (!dev_oe[7] && !par_oe[7])
		else $error("start exported above line 6");
	a_start_pulse: assert property ($rose(btb_in[6]) |=> btb_in[6] ##[1:16] !btb_in[6])
		else $error("start pulse too short to pass the filter or stuck");
	a_slave_no_sync: assert property (!par_oe[9] && !par_oe[8])
		else $error("slave drives timebase or sync line");
	a_reset_quiet: assert property ($rose(nrst) |-> dev_oe == '0 && par_oe == '0)
		else $error("line driven right after reset");
	// main scenarios
	c_sync: cover property ($rose(sync_drv));
	c_start: cover property ($rose(btb_in[6]));
	c_tb_drop: cover property ($fell(dev_oe[8]));
endmodule

// ### tb/tb_multi_board_timebase_sync.sv
// bench: master end facing a slave end across the shared lines
// assumes: SETTLE_N cut to 4 samples so settle stays short; one 125 MHz clock
`timescale 1ns/1ns
module tb_multi_board_timebase_sync import mbts_pkg::*; ;
	typedef struct packed {logic dexp; logic [3:0] line; logic [6:0] want;} mbts_row_t;
	logic clk = 0;
	logic nrst, go, use_star, tb_en, sync_en, d_exp, d_req, p_exp, p_req;
	logic [4:0] slot;
	logic [3:0] tb_sel, sync_sel, d_line, p_line, p_sync, rdiv;
	logic arej;
	logic d_crst, d_run, s_err, p_crst, p_run, cclk, crst_seen;
	logic [2:0] st;
	logic [6:0] seen;
	int bad_count = 0;
	int n_tests = 0;
	mbts_row_t rows [4] = '{'{1, 4'h0, 7'h01}, '{1, 4'h6, 7'h40}, '{1, 4'hF, 7'h40},
		'{0, 4'h2, 7'h04}};
	logic [4:0] slots [4] = '{5'h02, 5'h03, 5'h0E, 5'h0F};

	mbts_if link (.clk(clk));
	mbts_dev #(.SETTLE_N(4), .TB_SETTLE_N(16)) u_mbts_dev (.clk(clk), .nrst(nrst),
		.link(link), .go(go), .is_master(1'b1), .use_star(use_star), .slot(slot),
		.tb_line_sel_en(tb_en), .tb_line_sel(tb_sel), .sync_line_sel_en(sync_en),
		.sync_line_sel(sync_sel), .start_export(d_exp), .start_line(d_line),
		.start_req(d_req), .rate_div_log2(rdiv), .alias_rej(arej), .conv_clk(cclk),
		.conv_rst(d_crst), .acq_run(d_run), .slot_error(s_err), .state_out(st));
	mbts_par #(.SETTLE_N(4)) u_mbts_par (.clk(clk), .nrst(nrst), .link(link), .go(go),
		.sync_line(p_sync), .start_line(p_line), .start_export(p_exp), .start_req(p_req),
		.conv_rst(p_crst), .acq_run(p_run));
	mbts_monitor u_mbts_monitor (.clk(clk), .nrst(nrst), .btb_in(link.btb_in),
		.dev_out(link.dev_out), .dev_oe(link.dev_oe), .par_out(link.par_out),
		.par_oe(link.par_oe), .star_tb(link.star_tb));

	always #4 clk = ~clk;
	// remember which start lines pulsed and whether converters were reset
	always @(posedge clk) begin
		seen <= seen | link.btb_in[6:0];
		if (d_crst === 1'b1 && p_crst === 1'b1) crst_seen <= 1'b1;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk1(input logic got, input logic exp, input string what);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask
	task automatic chk7(input logic [6:0] got, input logic [6:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t start lines %h", $time, got);
		end
	endtask
	// one full converter clock period in cycles, rise to rise, each wait bounded
	task automatic chk_period(input int exp);
		int n;
		int k;
		n = 0;
		for (k = 0; k < 200 && cclk !== 1'b0; k++) step(1);
		for (k = 0; k < 200 && cclk !== 1'b1; k++) step(1);
		for (k = 0; k < 200 && cclk === 1'b1; k++) begin
			step(1);
			n++;
		end
		for (k = 0; k < 200 && cclk !== 1'b1; k++) begin
			step(1);
			n++;
		end
		n_tests++;
		if (n != exp) begin
			bad_count++;
			$display("[ERR] %0t converter clock period %0d", $time, n);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d, checks %0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// bounded wait until both ends acquire; settle time is unknown, so generous
	task automatic wait_run();
		int i;
		for (i = 0; i < 3000 && !(d_run === 1'b1 && p_run === 1'b1); i++) step(1);
		if (i == 3000) begin
			bad_count++;
			$display("[ERR] %0t acquisition never started", $time);
			give_verdict();
		end
	endtask
	task automatic stop();
		go = 0;
		d_req = 0;
		p_req = 0;
		step(3);
		seen = '0;
		crst_seen = 0;
	endtask

	initial begin
		{nrst, go, use_star, tb_en, sync_en, d_exp, d_req, p_exp, p_req} = '0;
		{slot, tb_sel, sync_sel, d_line, p_line, rdiv, arej} = '0;
		p_sync = SYNC_LINE_DEFAULT;
		seen = '0;
		crst_seen = 0;
		step(16);
		nrst = 1;
		// row loop: exporter and start line, expected pulsing line
		foreach (rows[i]) begin
			d_exp = rows[i].dexp;
			p_exp = !rows[i].dexp;
			d_line = rows[i].line;
			p_line = (rows[i].line > 4'h6) ? 4'h6 : rows[i].line;
			d_req = 1;
			p_req = 1;
			go = 1;
			wait_run();
			chk7(seen, rows[i].want);
			chk1(crst_seen, 1'b1, "no joint converter reset");
			chk1(link.dev_oe[8], 1'b1, "timebase not on line 8");
			stop();
		end
		// converter clock follows the divider; alias rejection runs it faster
		{d_exp, p_exp, d_line, p_line} = {2'b10, 4'h0, 4'h0};
		rdiv = 4'h3; // partner has no rate or alias filter of its own
		for (int j = 0; j < 2; j++) begin
			arej = (j == 0);
			{d_req, go} = 2'b11;
			wait_run();
			chk_period(arej ? (2 << (rdiv - ALIAS_OSR_LOG2)) : (2 << rdiv));
			stop();
		end
		{rdiv, arej} = '0;
		// early start: partner syncs on the slow timebase line and fires before master settles
		{tb_en, sync_en, tb_sel, sync_sel, p_sync, rdiv} = {2'b11, 4'h3, 4'h4, 4'h3, 4'h4};
		{d_line, p_line, d_exp, p_exp} = {4'h2, 4'h2, 2'b01};
		{go, p_req} = 2'b11;
		step(300);
		chk1(p_run, 1'b1, "partner start not sent");
		chk1(d_run, 1'b0, "early start taken");
		stop();
		// other timebase and sync lines
		{p_sync, rdiv} = {4'h4, 4'h0};
		{go, p_req} = 2'b11;
		wait_run();
		chk1(link.dev_oe[3], 1'b1, "timebase not on chosen line");
		stop();
		{tb_en, sync_en, p_sync} = {2'b00, SYNC_LINE_DEFAULT};
		// star route slot bounds
		use_star = 1;
		foreach (slots[i]) begin
			slot = slots[i];
			{go, p_req} = 2'b11;
			step(6);
			chk1(s_err, slot < 5'h03 || slot > 5'h0E, "slot range");
			if (slot >= 5'h03 && slot <= 5'h0E) wait_run();
			stop();
		end
		// reset after go, with no start requested, releases every line
		use_star = 0;
		go = 1;
		step(30);
		nrst = 0;
		step(2);
		chk1(|link.dev_oe, 1'b0, "lines held in reset");
		chk1(d_run, 1'b0, "run held in reset");
		go = 0;
		nrst = 1;
		step(4);
		give_verdict();
	end
endmodule
